/* upstream_qos_flow_sequencer.sv */
// Notes on behaviour
// - each received burst is tied to the service_identifier it was granted under
// - table indexed by the low six service_identifier bits and logical channel selects header qos
// - both data pseudowire types carry at least four qos levels
// - ranging, request, map and spectrum pseudowires carry one level each
// - every qos level gets its own distinct flow identifier
// - each flow has its own sequence counter, independent of others
// - each level maps statically to vlan priority, ipv4 tos, ipv6 class
// - mapping may place any level at any value of each field
// - no inspection of carried ip packets; lookup alone classifies
// - sequence numbering and its checking stay within one qos level
// - valid sequence numbers go on every upstream pseudowire
// - trailer from end status and block_a; header from start status
// - logical channel is conveyed through the pseudowire session identifier
`default_nettype none

module upstream_qos_flow_sequencer (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst,
  // logical channel indication ahead of a burst
  input  wire logic                            lch_valid,
  input  wire logic [qos_seq_pkg::LCH_W-1:0]   lch_id,
  // start of burst
  input  wire logic                            start_valid,
  output logic                                 start_ready,
  input  wire qos_seq_pkg::burst_start_s       start_data,
  // end of burst
  input  wire logic                            end_valid,
  output logic                                 end_ready,
  input  wire logic [qos_seq_pkg::STAT_W-1:0]  end_stat,
  // block_a status after the end of burst
  input  wire logic                            block_a_valid,
  output logic                                 block_a_ready,
  input  wire logic [qos_seq_pkg::PHY_W-1:0]   block_a_stat,
  // classification table write
  input  wire logic                            cls_we,
  input  wire logic [qos_seq_pkg::SID_W-1:0]   cls_sid,
  input  wire logic [qos_seq_pkg::LCH_W-1:0]   cls_lch,
  input  wire logic [qos_seq_pkg::LVL_W-1:0]   cls_level,
  // qos header map write, one entry per flow
  input  wire logic                            map_we,
  input  wire logic [qos_seq_pkg::SLOT_W-1:0]  map_slot,
  input  wire qos_seq_pkg::qos_map_s           map_data,
  // session identifier write, one per logical channel
  input  wire logic                            sess_we,
  input  wire logic [qos_seq_pkg::LCH_W-1:0]   sess_lch,
  input  wire logic [qos_seq_pkg::SESS_W-1:0]  sess_id,
  // header descriptor out
  output logic                                 hdr_valid,
  input  wire logic                            hdr_ready,
  output qos_seq_pkg::hdr_out_s                hdr_data,
  // trailer descriptor out
  output logic                                 trl_valid,
  input  wire logic                            trl_ready,
  output qos_seq_pkg::trl_out_s                trl_data,
  // status
  output logic                                 no_lch_seen
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    qos_seq_pkg::fsm_e                                             st;
    logic [qos_seq_pkg::TBL_N-1:0][qos_seq_pkg::LVL_W-1:0]         cls;
    logic [qos_seq_pkg::SLOT_N-1:0][$bits(qos_seq_pkg::qos_map_s)-1:0] qmap;
    logic [qos_seq_pkg::LCH_N-1:0][qos_seq_pkg::SESS_W-1:0]        sess;
    logic [qos_seq_pkg::LCH_W-1:0]                                 lch;
    logic                                                          lch_seen;
    logic                                                          no_lch;
    logic [qos_seq_pkg::SLOT_W-1:0]                                slot;
    qos_seq_pkg::hdr_out_s                                         hdr;
    qos_seq_pkg::trl_out_s                                         trl;
  } frm_state_s;

  frm_state_s st_r;
  frm_state_s st_nxt;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // table index from granted identifier and channel
  function automatic logic [qos_seq_pkg::TBL_W-1:0] tbl_index(
    input logic [qos_seq_pkg::SID_W-1:0] service_identifier,
    input logic [qos_seq_pkg::LCH_W-1:0] lch
  );
    tbl_index = {service_identifier[qos_seq_pkg::SID_IDX_W-1:0], lch};
  endfunction : tbl_index

  // true for the two data pseudowire types
  function automatic logic is_data_pw(input logic [qos_seq_pkg::PW_W-1:0] pw);
    is_data_pw = (pw == qos_seq_pkg::PW_SINGLE_CARRIER) ||
                 (pw == qos_seq_pkg::PW_MULTICARRIER);
  endfunction : is_data_pw

  // flow slot: one per pseudowire type and level
  function automatic logic [qos_seq_pkg::SLOT_W-1:0] flow_slot(
    input logic [qos_seq_pkg::PW_W-1:0]  pw,
    input logic [qos_seq_pkg::LVL_W-1:0] lvl
  );
    flow_slot = {pw, lvl};
  endfunction : flow_slot

  // ---------------------------------------------------------------
  // lookup for the burst being offered
  // ---------------------------------------------------------------
  logic [qos_seq_pkg::LCH_W-1:0]  cur_lch;
  logic [qos_seq_pkg::LVL_W-1:0]  cur_lvl;
  logic [qos_seq_pkg::SLOT_W-1:0] cur_slot;
  logic [qos_seq_pkg::SEQ_W-1:0]  cur_seq;
  logic                           seq_adv;
  logic [qos_seq_pkg::SLOT_W-1:0] rd_slot;

  // a channel indication in the same cycle as the start is taken at once
  always_comb begin
    cur_lch  = lch_valid ? lch_id : st_r.lch;
    cur_lvl  = st_r.cls[tbl_index(start_data.service_identifier, cur_lch)];
    if (!is_data_pw(start_data.pw)) begin
      cur_lvl = qos_seq_pkg::LVL_CTL;
    end
    cur_slot = flow_slot(start_data.pw, cur_lvl);
  end

  // ---------------------------------------------------------------
  // per-flow sequence counters
  // ---------------------------------------------------------------
  assign rd_slot = cur_slot;
  assign seq_adv = (st_r.st == qos_seq_pkg::S_HDR) && hdr_ready;

  seq_bank i_seq_bank (
    .clk      (clk),
    .rst      (rst),
    .adv      (seq_adv),
    .adv_slot (st_r.slot),
    .rd_slot  (rd_slot),
    .rd_seq   (cur_seq)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;

    // control plane table fills, accepted at any time
    if (cls_we) begin
      st_nxt.cls[tbl_index(cls_sid, cls_lch)] = cls_level;
    end
    if (map_we) begin
      st_nxt.qmap[map_slot] = map_data;
    end
    if (sess_we) begin
      st_nxt.sess[sess_lch] = sess_id;
    end

    // remember the latest channel indication
    if (lch_valid) begin
      st_nxt.lch      = lch_id;
      st_nxt.lch_seen = 1'b1;
    end

    unique case (st_r.st)
      qos_seq_pkg::S_IDLE: begin
        if (start_valid) begin
          st_nxt.slot          = cur_slot;
          st_nxt.no_lch        = !(st_r.lch_seen || lch_valid);
          st_nxt.lch_seen      = 1'b0;
          st_nxt.hdr.flow_id   = cur_slot;
          st_nxt.hdr.seq       = cur_seq;
          st_nxt.hdr.session   = st_r.sess[cur_lch];
          st_nxt.hdr.lch       = cur_lch;
          st_nxt.hdr.pw        = start_data.pw;
          st_nxt.hdr.level     = cur_lvl;
          st_nxt.hdr.qos       = st_r.qmap[cur_slot];
          st_nxt.hdr.stat      = start_data.stat;
          st_nxt.trl.flow_id   = cur_slot;
          st_nxt.trl.seq       = cur_seq;
          st_nxt.st            = qos_seq_pkg::S_HDR;
        end
      end
      qos_seq_pkg::S_HDR: begin
        if (hdr_ready) begin
          st_nxt.st = qos_seq_pkg::S_END;
        end
      end
      qos_seq_pkg::S_END: begin
        if (end_valid) begin
          st_nxt.trl.end_stat = end_stat;
          st_nxt.st           = qos_seq_pkg::S_STAT;
        end
      end
      qos_seq_pkg::S_STAT: begin
        if (block_a_valid) begin
          st_nxt.trl.phy_stat = block_a_stat;
          st_nxt.st           = qos_seq_pkg::S_TRL;
        end
      end
      qos_seq_pkg::S_TRL: begin
        if (trl_ready) begin
          st_nxt.st = qos_seq_pkg::S_IDLE;
        end
      end
      default: begin
        st_nxt.st = qos_seq_pkg::S_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r    <= '0;
      st_r.st <= qos_seq_pkg::S_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // handshakes follow the state
  assign start_ready   = (st_r.st == qos_seq_pkg::S_IDLE);
  assign end_ready     = (st_r.st == qos_seq_pkg::S_END);
  assign block_a_ready = (st_r.st == qos_seq_pkg::S_STAT);
  assign hdr_valid     = (st_r.st == qos_seq_pkg::S_HDR);
  assign trl_valid     = (st_r.st == qos_seq_pkg::S_TRL);

  // descriptors straight from flops
  assign hdr_data    = st_r.hdr;
  assign trl_data    = st_r.trl;
  assign no_lch_seen = st_r.no_lch;

endmodule : upstream_qos_flow_sequencer

`default_nettype wire

/* qos_seq_pkg.sv */
`default_nettype none

package qos_seq_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // widths and sizes
  // ---------------------------------------------------------------
  localparam int SID_W     = 14;              // granted service_identifier
  localparam int SID_IDX_W = 6;               // low bits used to index the table
  localparam int LCH_W     = 3;               // logical channel id
  localparam int LCH_N     = 1 << LCH_W;
  localparam int LVL_W     = 2;               // four qos levels per data pseudowire
  localparam int LVL_N     = 1 << LVL_W;
  localparam int PW_W      = 3;
  localparam int SLOT_W    = PW_W + LVL_W;    // one flow per pseudowire and level
  localparam int SLOT_N    = 1 << SLOT_W;
  localparam int TBL_W     = SID_IDX_W + LCH_W;
  localparam int TBL_N     = 1 << TBL_W;
  localparam int SEQ_W     = 16;
  localparam int SESS_W    = 32;
  localparam int STAT_W    = 8;
  localparam int PHY_W     = 16;
  localparam int PCP_W     = 3;               // vlan priority tag
  localparam int TOS_W     = 8;               // ipv4 type of service
  localparam int TC_W      = 8;               // ipv6 traffic class

  // ---------------------------------------------------------------
  // reset values, counter step and control level
  // ---------------------------------------------------------------
  localparam logic [SEQ_W-1:0] SEQ_RST  = 16'h0000;
  localparam logic [SEQ_W-1:0] SEQ_STEP = 16'h0001;
  localparam logic [LVL_W-1:0] LVL_RST  = 2'h0;
  localparam logic [LVL_W-1:0] LVL_CTL  = 2'h0;  // level of single-level pseudowires

  // ---------------------------------------------------------------
  // pseudowire types
  // ---------------------------------------------------------------
  localparam logic [PW_W-1:0] PW_SINGLE_CARRIER = 3'h0;
  localparam logic [PW_W-1:0] PW_MULTICARRIER   = 3'h1;
  localparam logic [PW_W-1:0] PW_RANGING        = 3'h2;
  localparam logic [PW_W-1:0] PW_REQUEST        = 3'h3;
  localparam logic [PW_W-1:0] PW_ALLOC_MAP      = 3'h4;
  localparam logic [PW_W-1:0] PW_SPECTRUM       = 3'h5;

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_HDR  = 5'h02,
    S_END  = 5'h04,
    S_STAT = 5'h08,
    S_TRL  = 5'h10
  } fsm_e;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [PW_W-1:0]   pw;
    logic [SID_W-1:0]  service_identifier;
    logic [STAT_W-1:0] stat;
  } burst_start_s;

  typedef struct packed {
    logic [PCP_W-1:0] pcp;
    logic [TOS_W-1:0] tos;
    logic [TC_W-1:0]  tc;
  } qos_map_s;

  typedef struct packed {
    logic [SLOT_W-1:0] flow_id;
    logic [SEQ_W-1:0]  seq;
    logic [SESS_W-1:0] session;
    logic [LCH_W-1:0]  lch;
    logic [PW_W-1:0]   pw;
    logic [LVL_W-1:0]  level;
    qos_map_s          qos;
    logic [STAT_W-1:0] stat;
  } hdr_out_s;

  typedef struct packed {
    logic [SLOT_W-1:0] flow_id;
    logic [SEQ_W-1:0]  seq;
    logic [STAT_W-1:0] end_stat;
    logic [PHY_W-1:0]  phy_stat;
  } trl_out_s;

  typedef struct packed {
    logic [SLOT_N-1:0][SEQ_W-1:0] cnt;
  } seq_state_s;

endpackage : qos_seq_pkg

`default_nettype wire

/* seq_bank.sv */
`default_nettype none

module seq_bank (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst,
  // advance one flow
  input  wire logic                           adv,
  input  wire logic [qos_seq_pkg::SLOT_W-1:0] adv_slot,
  // read one flow
  input  wire logic [qos_seq_pkg::SLOT_W-1:0] rd_slot,
  output logic      [qos_seq_pkg::SEQ_W-1:0]  rd_seq
);
  timeunit 1ns;
  timeprecision 1ps;

  qos_seq_pkg::seq_state_s st_r;
  qos_seq_pkg::seq_state_s st_nxt;

  // ---------------------------------------------------------------
  // next counters
  // ---------------------------------------------------------------
  // only the addressed flow moves, others hold
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < qos_seq_pkg::SLOT_N; i++) begin
      if (adv && (adv_slot == i[qos_seq_pkg::SLOT_W-1:0])) begin
        st_nxt.cnt[i] = st_r.cnt[i] + qos_seq_pkg::SEQ_STEP;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // current number of the read flow
  assign rd_seq = st_r.cnt[rd_slot];

endmodule : seq_bank

`default_nettype wire

/* upstream_qos_flow_sequencer_checker.sv */
`default_nettype none

module flow_seq_checker (
  // clock and reset
  input wire logic                          clk,
  input wire logic                          rst,
  // burst side
  input wire logic                          start_valid,
  input wire logic                          start_ready,
  input wire qos_seq_pkg::burst_start_s     start_data,
  input wire logic                          end_ready,
  input wire logic                          block_a_valid,
  input wire logic                          block_a_ready,
  input wire logic [qos_seq_pkg::PHY_W-1:0] block_a_stat,
  // descriptors
  input wire logic                          hdr_valid,
  input wire logic                          hdr_ready,
  input wire qos_seq_pkg::hdr_out_s         hdr_data,
  input wire logic                          trl_valid,
  input wire logic                          trl_ready,
  input wire qos_seq_pkg::trl_out_s         trl_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [qos_seq_pkg::SLOT_W-1:0]                         flow_r;
  logic [qos_seq_pkg::SEQ_W-1:0]                          seq_r;
  logic [qos_seq_pkg::SLOT_N-1:0][qos_seq_pkg::SEQ_W-1:0] next_r;

  // last header handed to the receiver
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flow_r <= '0;
      seq_r  <= '0;
      next_r <= '0;
    end else if (hdr_valid && hdr_ready) begin
      flow_r                   <= hdr_data.flow_id;
      seq_r                    <= hdr_data.seq;
      next_r[hdr_data.flow_id] <= hdr_data.seq + qos_seq_pkg::SEQ_STEP;
    end
  end

  // ----------------------------------------
  // steps of a burst
  // ----------------------------------------
  sequence s_start; start_valid && start_ready; endsequence
  sequence s_hold; hdr_valid && !hdr_ready; endsequence
  sequence s_take; hdr_valid && hdr_ready; endsequence
  sequence s_stat; block_a_valid && block_a_ready; endsequence

  a_hdr_follows: assert property (
    s_start |=> hdr_valid && !start_ready) else $error("no header after start");
  a_hdr_fields: assert property (
    s_start |=> hdr_data.pw == $past(start_data.pw) && hdr_data.stat == $past(start_data.stat))
    else $error("header fields not from start");
  a_hdr_stands: assert property (
    s_hold |=> hdr_valid && $stable(hdr_data)) else $error("header dropped");
  a_end_next: assert property (
    s_take |=> end_ready && !hdr_valid) else $error("end not offered after header");
  a_flow_split: assert property (
    hdr_valid |-> hdr_data.flow_id == {hdr_data.pw, hdr_data.level}) else $error("flow id");
  a_ctl_level: assert property (
    hdr_valid && hdr_data.pw > qos_seq_pkg::PW_MULTICARRIER |-> hdr_data.level == 2'h0)
    else $error("control level not single");
  a_trl_follows: assert property (
    s_stat |=> trl_valid && trl_data.phy_stat == $past(block_a_stat)) else $error("trailer");
  a_trl_pairs: assert property (
    trl_valid |-> trl_data.flow_id == flow_r && trl_data.seq == seq_r) else $error("pairing");
  a_start_shut: assert property (
    trl_valid |-> !start_ready) else $error("start open during trailer");
  a_seq_steps: assert property (
    hdr_valid |-> hdr_data.seq == next_r[hdr_data.flow_id]) else $error("sequence step");
  a_trl_stands: assert property (
    trl_valid && !trl_ready |=> trl_valid && $stable(trl_data)) else $error("trailer dropped");
endmodule : flow_seq_checker

bind upstream_qos_flow_sequencer flow_seq_checker i_flow_seq_checker (
  .clk, .rst, .start_valid, .start_ready, .start_data, .end_ready, .block_a_valid,
  .block_a_ready, .block_a_stat, .hdr_valid, .hdr_ready, .hdr_data, .trl_valid,
  .trl_ready, .trl_data
);

`default_nettype wire

/* core_receiver_model.sv */
`default_nettype none

module core_receiver_model (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  rst,
  // pacing
  input wire logic                  slow,
  // descriptors
  input wire logic                  hdr_valid,
  output logic                      hdr_ready,
  input wire qos_seq_pkg::hdr_out_s hdr_data,
  input wire logic                  trl_valid,
  output logic                      trl_ready,
  input wire qos_seq_pkg::trl_out_s trl_data,
  // faults seen
  output int                        gap_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [qos_seq_pkg::SEQ_W-1:0] want [qos_seq_pkg::SLOT_N];
  logic [1:0]                    pace;

  initial gap_count = 0;

  // readies, paced when slow
  always @(negedge clk) begin
    pace      <= rst ? 2'h0 : pace + 2'h1;
    hdr_ready <= !slow || pace == 2'h0;
    trl_ready <= !slow || pace == 2'h2;
  end

  // per-flow check only, no reordering
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      foreach (want[i]) want[i] = '0;
    end else begin
      if (hdr_valid && hdr_ready) begin
        if (hdr_data.seq !== want[hdr_data.flow_id]) gap_count++;
        want[hdr_data.flow_id] = hdr_data.seq + 16'h0001;
      end
      if (trl_valid && trl_ready && trl_data.seq + 16'h0001 !== want[trl_data.flow_id])
        gap_count++;
    end
  end
endmodule : core_receiver_model

`default_nettype wire

/* upstream_qos_flow_sequencer_tb_top.sv */
`default_nettype none

module upstream_qos_flow_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0]  pw;
    logic [2:0]  lch;
    logic [13:0] grant;
    logic [1:0]  lv;
  } row_s;

  logic                         clk, rst, lch_valid, start_valid, start_ready, end_valid;
  logic                         end_ready, block_a_valid, block_a_ready, cls_we, map_we;
  logic                         sess_we, hdr_valid, hdr_ready, trl_valid, trl_ready;
  logic                         no_lch_seen, slow;
  logic [2:0]                   lch_id, cls_lch, sess_lch;
  logic [13:0]                  cls_sid;
  logic [1:0]                   cls_level;
  logic [4:0]                   map_slot;
  logic [7:0]                   end_stat;
  logic [15:0]                  block_a_stat;
  logic [31:0]                  sess_id;
  qos_seq_pkg::qos_map_s        map_data;
  qos_seq_pkg::burst_start_s    start_data;
  qos_seq_pkg::hdr_out_s        hdr_data;
  qos_seq_pkg::trl_out_s        trl_data;
  logic [15:0]                  exp_seq [32];
  int                           bad_count, n_tests, gaps, p, k;
  row_s                         rows [8] = '{
    '{3'h0, 3'h1, 14'h0005, 2'h3}, '{3'h0, 3'h1, 14'h0045, 2'h2},
    '{3'h1, 3'h2, 14'h3FFF, 2'h1}, '{3'h1, 3'h7, 14'h0000, 2'h0},
    '{3'h2, 3'h0, 14'h0011, 2'h3}, '{3'h3, 3'h4, 14'h0012, 2'h1},
    '{3'h4, 3'h5, 14'h0013, 2'h2}, '{3'h5, 3'h6, 14'h0014, 2'h3}};

  upstream_qos_flow_sequencer i_upstream_qos_flow_sequencer (
    .clk, .rst, .lch_valid, .lch_id, .start_valid, .start_ready, .start_data, .end_valid,
    .end_ready, .end_stat, .block_a_valid, .block_a_ready, .block_a_stat, .cls_we, .cls_sid,
    .cls_lch, .cls_level, .map_we, .map_slot, .map_data, .sess_we, .sess_lch, .sess_id,
    .hdr_valid, .hdr_ready, .hdr_data, .trl_valid, .trl_ready, .trl_data, .no_lch_seen);

  core_receiver_model i_core_receiver_model (
    .clk, .rst, .slow, .hdr_valid, .hdr_ready, .hdr_data, .trl_valid, .trl_ready, .trl_data,
    .gap_count(gaps));

  always #5 clk = ~clk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] sess_of(input logic [2:0] l);
    return {l, 26'h0, ~l};
  endfunction : sess_of

  function automatic qos_seq_pkg::qos_map_s map_of(input logic [4:0] s);
    return '{s[2:0], ~{3'h0, s}, {s, 3'h0}};
  endfunction : map_of

  task automatic test_done();
    $display("checks %0d mismatches %0d gaps %0d", n_tests, bad_count, gaps);
    if (bad_count == 0 && gaps == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [127:0] got, input logic [127:0] want);
    n_tests++;
    if (got !== want) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk

  // bounded wait on a ready: 0 start, 1 end, 2 block_a
  task automatic hold_for(input int w);
    int n;
    for (n = 0; n < 40 && !(w == 0 ? start_ready : w == 1 ? end_ready : block_a_ready); n++)
      @(negedge clk);
    if (n == 40) begin
      bad_count++;
      test_done();
    end
  endtask : hold_for

  task automatic load_tables();
    for (int i = 0; i < 32; i++) begin
      @(negedge clk);
      map_we   = 1'b1;
      map_slot = i[4:0];
      map_data = map_of(i[4:0]);
      sess_we  = i < 8;
      sess_lch = i[2:0];
      sess_id  = sess_of(i[2:0]);
    end
    @(negedge clk);
    map_we  = 1'b0;
    sess_we = 1'b0;
  endtask : load_tables

  task automatic burst(input row_s r, input logic ind, input logic ld);
    qos_seq_pkg::hdr_out_s eh;
    logic [4:0]            f;
    logic [7:0]            st;
    f  = {r.pw, (r.pw > qos_seq_pkg::PW_MULTICARRIER) ? 2'h0 : r.lv};
    st = {r.lch, r.pw, r.lv};
    eh = '{f, exp_seq[f], ld ? sess_of(r.lch) : '0, r.lch, r.pw, f[1:0], map_of(f), st};
    if (!ld) eh.qos = '0;
    @(negedge clk);
    lch_valid = ind;
    lch_id    = r.lch;
    cls_we    = 1'b1;
    cls_sid   = r.grant;
    cls_lch   = r.lch;
    cls_level = r.lv;
    @(negedge clk);
    lch_valid = 1'b0;
    cls_we    = 1'b0;
    hold_for(0);
    start_valid = 1'b1;
    start_data  = '{r.pw, r.grant, st};
    @(negedge clk);
    start_valid = 1'b0;
    chk({hdr_valid, no_lch_seen, hdr_data}, {1'b1, !ind, eh});
    hold_for(1);
    end_valid = 1'b1;
    end_stat  = ~st;
    @(negedge clk);
    end_valid  = 1'b0;
    exp_seq[f] = exp_seq[f] + 16'h0001;
    hold_for(2);
    block_a_valid = 1'b1;
    block_a_stat  = {st, ~st};
    @(negedge clk);
    block_a_valid = 1'b0;
    chk({trl_valid, trl_data}, {1'b1, f, eh.seq, ~st, st, ~st});
  endtask : burst

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {clk, lch_valid, start_valid, end_valid, block_a_valid, cls_we, map_we, sess_we} = '0;
    {lch_id, cls_lch, sess_lch, cls_sid, cls_level, map_slot, end_stat} = '0;
    {block_a_stat, sess_id, map_data, start_data, slow} = '0;
    {bad_count, n_tests} = '0;
    foreach (exp_seq[i]) exp_seq[i] = '0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    load_tables();
    for (p = 0; p < 2; p++) begin
      slow = p[0];
      for (k = 0; k < 8; k++) burst(rows[k], 1'b1, 1'b1);
    end
    // no channel indication: last channel reused
    burst(rows[7], 1'b0, 1'b1);
    // reset mid-run clears state and tables
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    chk({start_ready, hdr_valid, trl_valid, end_ready, block_a_ready, no_lch_seen}, 6'h20);
    rst = 1'b0;
    foreach (exp_seq[i]) exp_seq[i] = '0;
    burst(rows[4], 1'b1, 1'b0);
    load_tables();
    burst(rows[0], 1'b1, 1'b1);
    // channel indication in the start cycle wins over the latched one
    @(negedge clk);
    cls_we    = 1'b1;
    cls_sid   = rows[2].grant;
    cls_lch   = rows[2].lch;
    cls_level = rows[2].lv;
    @(negedge clk);
    cls_we = 1'b0;
    hold_for(0);
    lch_valid   = 1'b1;
    lch_id      = rows[2].lch;
    start_valid = 1'b1;
    start_data  = '{rows[2].pw, rows[2].grant, 8'h5A};
    @(negedge clk);
    lch_valid   = 1'b0;
    start_valid = 1'b0;
    chk({hdr_valid, no_lch_seen, hdr_data.flow_id, hdr_data.seq}, {2'h2, 5'h05, exp_seq[5]});
    chk(hdr_data.session, sess_of(rows[2].lch));
    test_done();
  end
endmodule : upstream_qos_flow_sequencer_tb_top

`default_nettype wire
